// File: hw/otps_irq_regs.sv
/*
 Sticky event status, enable mask and level interrupt output.
 Assumes event pulses and write strobes are single-cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module otps_irq_regs #(
    parameter int W = 7
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] eventPulse,
    input  wire logic         clrWrite,
    input  wire logic         enWrite,
    input  wire logic [W-1:0] wrData,
    output logic      [W-1:0] status,
    output logic      [W-1:0] enable,
    output logic              irq
);

    // Status and enable each read back in one bus word
    if (W < 1 || W > 32) begin : g_bad_w
        $error("W must lie between 1 and 32");
    end

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] enable;
        logic         irq;
    } otps_irq_state_t;

    otps_irq_state_t st_q;
    otps_irq_state_t st_d;

    always_comb begin
        st_d = st_q;
        // Set wins over a clear in the same cycle
        if (clrWrite) begin
            st_d.status = st_q.status & ~wrData;
        end
        st_d.status = st_d.status | eventPulse;
        if (enWrite) begin
            st_d.enable = wrData;
        end
        st_d.irq = |(st_d.status & st_d.enable);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign status = st_q.status;
    assign enable = st_q.enable;
    assign irq    = st_q.irq;

endmodule

`default_nettype wire

// File: hw/otps_out_select.sv
/*
 Per-output signal selector and polarity stage, purely combinational.
 Assumes function and polarity codes come from registered settings.
*/
`timescale 1ns/1ps
`default_nettype none

module otps_out_select (
    input  wire logic [5:0]           funcCode,
    input  wire logic [1:0]           polCode,
    input  wire otps_pkg::otps_flags_t flags,
    output logic                      sigAsserted,
    output logic                      conduct
);

    always_comb begin
        unique case (funcCode)
            otps_pkg::FN_RUN:   sigAsserted = flags.motorRunning | flags.dcBrakeActive;
            otps_pkg::FN_FWD:   sigAsserted = flags.forwardRotationFlag;
            otps_pkg::FN_REV:   sigAsserted = flags.reverseRotationFlag;
            otps_pkg::FN_MAJ:   sigAsserted = flags.majorFailureFlag;
            otps_pkg::FN_WC_V:  sigAsserted = flags.windowCmpVoltageInput;
            otps_pkg::FN_WC_I:  sigAsserted = flags.windowCmpCurrentInput;
            otps_pkg::FN_WC_V2: sigAsserted = flags.windowCmpSecondVoltageInput;
            // Unsupported codes hold the output deasserted
            default:            sigAsserted = 1'b0;
        endcase
        // Undefined polarity codes behave as normally-open
        if (polCode == otps_pkg::POL_NC) begin
            conduct = ~sigAsserted;
        end else begin
            conduct = sigAsserted;
        end
    end

endmodule

`default_nettype wire

// File: hw/otps_output_stage.sv
/*
 Output terminal stage: function select, polarity and relay control
 for open-collector terminals and one changeover alarm relay, with
 an Avalon-MM register slave and an event interrupt.
 Assumes drive status flags are synchronous to clk and that powerOn
 low models an unpowered drive.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otps_map.svh"

module otps_output_stage #(
    parameter int NUM_TERM = 5
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [5:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire otps_pkg::otps_flags_t driveFlags,
    input  wire logic [NUM_TERM-1:0]   outputPinIn,
    output logic      [NUM_TERM-1:0]   outputPinOut,
    output logic      [NUM_TERM-1:0]   outputPinOeN,
    output logic                       relayFirstContactPair,
    output logic                       relaySecondContactPair,
    output logic                       irq
);

    localparam int NOUT = NUM_TERM + 1;
    localparam int NEV  = NOUT + 1;

    // Function registers must fit below the polarity register
    if (NUM_TERM < 1 || NUM_TERM > 5) begin : g_bad_num_term
        $error("NUM_TERM must lie between 1 and 5");
    end

    // Polarity fields of all outputs share one bus word
    if (NOUT * `OTPS_POL_W > 32) begin : g_bad_pol_word
        $error("Polarity fields overflow one word");
    end

    // Selected-signal bits sit below the sensed pin field
    if (NOUT > `OTPS_ST_PIN_LSB) begin : g_bad_state_sel
        $error("Selected-signal field overlaps pin field");
    end

    // Sensed pins sit below the power bit
    if (`OTPS_ST_PIN_LSB + NUM_TERM > `OTPS_ST_POWER_BIT) begin : g_bad_state_pin
        $error("Pin field overlaps power bit");
    end

    // Power and relay bits keep their order in the state word
    if (`OTPS_ST_POWER_BIT >= `OTPS_ST_RLY1_BIT
        || `OTPS_ST_RLY1_BIT >= `OTPS_ST_RLY2_BIT) begin : g_bad_state_order
        $error("State word bits out of order");
    end

    // Relay bits must fit the state word
    if (`OTPS_ST_RLY2_BIT > 31) begin : g_bad_state_top
        $error("Relay bits overflow one word");
    end

    // Every output event plus power loss fits one status word
    if (NEV > 32) begin : g_bad_ev_word
        $error("Event bits overflow one word");
    end

    // Register fields must be as wide as the shared code types
    if (`OTPS_FUNC_W != $bits(otps_pkg::otps_func_t)) begin : g_bad_func_w
        $error("Function field width differs from code type");
    end

    if (`OTPS_POL_W != $bits(otps_pkg::otps_pol_t)) begin : g_bad_pol_w
        $error("Polarity field width differs from code type");
    end

    typedef struct packed {
        logic [NOUT-1:0][`OTPS_FUNC_W-1:0] func;
        logic [NOUT-1:0][`OTPS_POL_W-1:0]  pol;
        logic [NOUT-1:0]                   asserted;
        logic                              powerPrev;
        logic [NUM_TERM-1:0]               pinOut;
        logic [NUM_TERM-1:0]               pinOeN;
        logic                              relayFirst;
        logic                              relaySecond;
        logic                              waitReq;
        logic [31:0]                       rdata;
    } otps_top_state_t;

    function automatic otps_top_state_t resetState();
        otps_top_state_t s;
        s = '0;
        for (int i = 0; i < NUM_TERM; i++) begin
            s.func[i] = `OTPS_TERM_FUNC_RST;
            s.pol[i]  = `OTPS_TERM_POL_RST;
        end
        s.func[NUM_TERM] = `OTPS_RELAY_FUNC_RST;
        s.pol[NUM_TERM]  = `OTPS_RELAY_POL_RST;
        s.pinOeN         = '1;
        s.relayFirst     = 1'b0;
        s.relaySecond    = 1'b1;
        s.waitReq        = 1'b1;
        return s;
    endfunction

    // Merge write data into an old word under the byte enables
    function automatic logic [31:0] beMerge(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = newVal[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Word-aligned address of a function select register
    function automatic logic isFuncAddr(
        input logic [5:0] addr
    );
        return addr[1:0] == 2'h0 && addr[5:2] < 4'(NOUT);
    endfunction

    // Live state word: selected signals, sensed pins, power, relay pairs
    function automatic logic [31:0] stateWord(
        input otps_top_state_t s
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        r[NOUT-1:0] = s.asserted;
        r[`OTPS_ST_PIN_LSB +: NUM_TERM] = outputPinIn;
        r[`OTPS_ST_POWER_BIT] = driveFlags.powerOn;
        r[`OTPS_ST_RLY1_BIT]  = s.relayFirst;
        r[`OTPS_ST_RLY2_BIT]  = s.relaySecond;
        return r;
    endfunction

    otps_top_state_t st_q;
    otps_top_state_t st_d;

    logic [NOUT-1:0] selAsserted;
    logic [NOUT-1:0] selConduct;
    logic [NEV-1:0]  evPulse;
    logic [NEV-1:0]  irqStatus;
    logic [NEV-1:0]  irqEnable;
    logic            irqLevel;
    logic            wrFire;
    logic            clrWrite;
    logic            enWrite;
    logic [NEV-1:0]  irqWrData;
    logic [31:0]     irqWrWord;
    logic [3:0]      wordIdx;
    logic            funcWrite;
    logic            polWrite;

    for (genvar i = 0; i < NOUT; i++) begin : g_sel
        otps_out_select u_sel (
            .funcCode    (st_q.func[i]),
            .polCode     (st_q.pol[i]),
            .flags       (driveFlags),
            .sigAsserted (selAsserted[i]),
            .conduct     (selConduct[i])
        );
    end

    // A write takes effect only at the edge that completes the transfer
    assign wrFire    = avs_write && !st_q.waitReq;
    assign wordIdx   = avs_address[5:2];
    assign clrWrite  = wrFire && (avs_address == `OTPS_IRQ_CLR_ADDR);
    assign enWrite   = wrFire && (avs_address == `OTPS_IRQ_EN_ADDR);
    assign irqWrWord = beMerge(32'h0000_0000, avs_writedata, avs_byteenable);
    assign irqWrData = irqWrWord[NEV-1:0];
    assign funcWrite = wrFire && isFuncAddr(avs_address);
    assign polWrite  = wrFire && (avs_address == `OTPS_POL_ADDR);

    // Events: each selected signal rising, and loss of drive power
    always_comb begin
        evPulse             = '0;
        evPulse[NOUT-1:0]   = selAsserted & ~st_q.asserted;
        evPulse[NOUT]       = st_q.powerPrev & ~driveFlags.powerOn;
    end

    otps_irq_regs #(
        .W (NEV)
    ) u_irq (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .eventPulse (evPulse),
        .clrWrite   (clrWrite),
        .enWrite    (enWrite),
        .wrData     (irqWrData),
        .status     (irqStatus),
        .enable     (irqEnable),
        .irq        (irqLevel)
    );

    function automatic logic [31:0] readMux(
        input logic [5:0]      addr,
        input otps_top_state_t s
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        if (isFuncAddr(addr)) begin
            r[`OTPS_FUNC_W-1:0] = s.func[addr[5:2]];
        end else begin
            case (addr)
                `OTPS_POL_ADDR: begin
                    r[NOUT*`OTPS_POL_W-1:0] = s.pol;
                end
                `OTPS_STATE_ADDR: begin
                    r = stateWord(s);
                end
                `OTPS_IRQ_STAT_ADDR: begin
                    r[NEV-1:0] = irqStatus;
                end
                `OTPS_IRQ_EN_ADDR: begin
                    r[NEV-1:0] = irqEnable;
                end
                // Clear register is write-only; unmapped reads give zero
                default: begin
                    r = 32'h0000_0000;
                end
            endcase
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] merged;
        merged = 32'h0000_0000;
        st_d = st_q;

        st_d.asserted  = selAsserted;
        st_d.powerPrev = driveFlags.powerOn;

        // Open-collector terminals never source current
        st_d.pinOut = '0;
        for (int i = 0; i < NUM_TERM; i++) begin
            // Unpowered terminals stay open
            st_d.pinOeN[i] = ~(driveFlags.powerOn & selConduct[i]);
        end

        if (!driveFlags.powerOn) begin
            st_d.relayFirst  = 1'b0;
            st_d.relaySecond = 1'b1;
        end else begin
            // Changeover contact: one pair is always the complement
            st_d.relayFirst  = selConduct[NUM_TERM];
            st_d.relaySecond = ~selConduct[NUM_TERM];
        end

        // One wait state per transfer, then one cycle of release
        if ((avs_read || avs_write) && st_q.waitReq) begin
            st_d.waitReq = 1'b0;
            st_d.rdata   = readMux(avs_address, st_q);
        end else begin
            st_d.waitReq = 1'b1;
        end

        if (funcWrite) begin
            merged = beMerge(32'(st_q.func[wordIdx]), avs_writedata, avs_byteenable);
            st_d.func[wordIdx] = merged[`OTPS_FUNC_W-1:0];
        end
        if (polWrite) begin
            merged = beMerge(32'(st_q.pol), avs_writedata, avs_byteenable);
            st_d.pol = merged[NOUT*`OTPS_POL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= resetState();
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata           = st_q.rdata;
    assign avs_waitrequest        = st_q.waitReq;
    assign outputPinOut           = st_q.pinOut;
    assign outputPinOeN           = st_q.pinOeN;
    assign relayFirstContactPair  = st_q.relayFirst;
    assign relaySecondContactPair = st_q.relaySecond;
    assign irq                    = irqLevel;

endmodule

`default_nettype wire

// File: inc/otps_map.svh
/*
 Register offsets, field widths and reset values of the output
 terminal polarity select block.
 Assumes byte addressing on a 32-bit Avalon-MM slave port.
*/
`ifndef OTPS_MAP_SVH
`define OTPS_MAP_SVH

// Byte offsets; function select of output i sits at FUNC_BASE + 4*i
`define OTPS_FUNC_BASE      6'h00
`define OTPS_POL_ADDR       6'h18
`define OTPS_STATE_ADDR     6'h1C
`define OTPS_IRQ_STAT_ADDR  6'h20
`define OTPS_IRQ_CLR_ADDR   6'h24
`define OTPS_IRQ_EN_ADDR    6'h28

// Field widths
`define OTPS_FUNC_W         6
`define OTPS_POL_W          2
`define OTPS_ADDR_W         6

// State register field positions
`define OTPS_ST_PIN_LSB     8
`define OTPS_ST_POWER_BIT   16
`define OTPS_ST_RLY1_BIT    17
`define OTPS_ST_RLY2_BIT    18

// Reset values
`define OTPS_TERM_FUNC_RST  6'h00
`define OTPS_RELAY_FUNC_RST 6'h35
`define OTPS_TERM_POL_RST   2'h0
`define OTPS_RELAY_POL_RST  2'h1

`endif

// File: inc/otps_pkg.sv
/*
 Types shared by the output terminal polarity select block.
 Assumes the map header supplies all offsets and reset values.
*/
package otps_pkg;

    typedef enum logic [5:0] {
        FN_RUN   = 6'h00,
        FN_FWD   = 6'h33,
        FN_REV   = 6'h34,
        FN_MAJ   = 6'h35,
        FN_WC_V  = 6'h36,
        FN_WC_I  = 6'h37,
        FN_WC_V2 = 6'h38
    } otps_func_t;

    typedef enum logic [1:0] {
        POL_NO = 2'h0,
        POL_NC = 2'h1
    } otps_pol_t;

    typedef struct packed {
        logic powerOn;
        logic motorRunning;
        logic dcBrakeActive;
        logic forwardRotationFlag;
        logic reverseRotationFlag;
        logic majorFailureFlag;
        logic windowCmpVoltageInput;
        logic windowCmpCurrentInput;
        logic windowCmpSecondVoltageInput;
    } otps_flags_t;

endpackage

// File: sim/otps_far_end.sv
/*
 Control equipment side: pull-up inputs reading the terminals.
 Assumes active-low output enables from the output stage.
*/
`timescale 1ns/1ps
`default_nettype none
module otps_far_end #(
    parameter int N = 5
) (
    input  wire logic [N-1:0] oeN,
    output logic      [N-1:0] pinLevel
);
    // Pull-up: an open terminal reads high, a conducting one low
    assign pinLevel = oeN;
endmodule
`default_nettype wire

// File: sim/otps_output_stage_bench.sv
/*
 Self-checking bench of the output stage over its Avalon-MM port.
 Assumes the far-end model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module otps_output_stage_bench;
    logic                  clk = 1'b0;
    logic                  rst, rdEn, wrEn, waitReq, rly1, rly2, irq;
    logic [5:0]            adr;
    logic [31:0]           wd, rdData, q;
    logic [4:0]            pinIn, pinOut, oeN;
    otps_pkg::otps_flags_t flags;
    int                    err_count = 0, samples_checked = 0, cyc = 0;
    always #12.5 clk = ~clk;
    otps_output_stage #(.NUM_TERM(5)) u_otps_output_stage (
        .clk(clk), .sys_rst(rst), .avs_address(adr), .avs_read(rdEn), .avs_write(wrEn),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdData),
        .avs_waitrequest(waitReq), .driveFlags(flags), .outputPinIn(pinIn),
        .outputPinOut(pinOut), .outputPinOeN(oeN), .relayFirstContactPair(rly1),
        .relaySecondContactPair(rly2), .irq(irq));
    otps_far_end #(.N(5)) u_otps_far_end (.oeN(oeN), .pinLevel(pinIn));
    task automatic end_sim;
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // Holds the request until waitrequest is seen low, then one idle edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wrEn <= w;
        rdEn <= !w;
        do @(posedge clk); while (waitReq !== 1'b0);
        q = rdData;
        wrEn <= 1'b0;
        rdEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic relay(input logic [31:0] p, input logic [8:0] f, input logic [1:0] e);
        bus(1'b1, 6'h18, p);
        flags <= f;
        tick(3);
        chk("relay", {30'h0, rly1, rly2}, {30'h0, e});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        rst <= 1'b1;
        rdEn <= 1'b0;
        wrEn <= 1'b0;
        adr <= 6'h00;
        wd <= 32'h0;
        flags <= 9'h000;
        tick(12);
        rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 6'(4 * i), 32'h0);
            chk("func", q, (i == 5) ? 32'h35 : 32'h0);
        end
        bus(1'b0, 6'h18, 32'h0);
        chk("polarity", q, 32'h400);
        bus(1'b0, 6'h2C, 32'h0);
        chk("unmapped", q, 32'h0);
        // Terminal 1 normally-closed, the rest normally-open, all on running
        bus(1'b1, 6'h18, 32'h404);
        for (int k = 0; k < 3; k++) begin
            flags <= (k == 0) ? 9'h180 : (k == 1) ? 9'h140 : 9'h100;
            tick(3);
            chk("terminals", {27'h0, oeN}, (k < 2) ? 32'h02 : 32'h1D);
            bus(1'b0, 6'h1C, 32'h0);
            chk("sensed", {27'h0, q[12:8]}, (k < 2) ? 32'h02 : 32'h1D);
        end
        for (int j = 0; j < 6; j++) begin
            bus(1'b1, 6'h08, 32'h33 + j);
            flags <= 9'h100 | (9'h020 >> j);
            tick(3);
            chk("code on", {31'h0, oeN[2]}, 32'h0);
            flags <= 9'h13F ^ (9'h020 >> j);
            tick(3);
            chk("code off", {31'h0, oeN[2]}, 32'h1);
        end
        relay(32'h404, 9'h100, 2'b10);
        relay(32'h404, 9'h108, 2'b01);
        relay(32'h004, 9'h108, 2'b10);
        relay(32'h004, 9'h008, 2'b01);
        relay(32'h404, 9'h008, 2'b01);
        chk("unpowered", {27'h0, oeN}, 32'h1F);
        bus(1'b0, 6'h20, 32'h0);
        chk("power lost", q & 32'h40, 32'h40);
        // Relay moved onto the running signal
        bus(1'b1, 6'h14, 32'h0);
        relay(32'h000, 9'h180, 2'b10);
        relay(32'h400, 9'h140, 2'b01);
        // Interrupt: raise on running edge, clear, then masked
        bus(1'b1, 6'h24, 32'h7F);
        bus(1'b1, 6'h28, 32'h1);
        flags <= 9'h100;
        tick(3);
        flags <= 9'h180;
        tick(4);
        chk("irq set", {31'h0, irq}, 32'h1);
        bus(1'b1, 6'h24, 32'h1);
        tick(2);
        chk("irq clear", {31'h0, irq}, 32'h0);
        bus(1'b1, 6'h28, 32'h0);
        flags <= 9'h100;
        tick(3);
        flags <= 9'h180;
        tick(4);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b0, 6'h20, 32'h0);
        chk("status", q & 32'h1, 32'h1);
        end_sim();
    end
endmodule
`default_nettype wire

// File: sim/otps_properties.sv
/*
 Port checker for the output stage.
 Assumes the bench writes with all byte lanes enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module otps_properties #(
    parameter int NUM_TERM = 5
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic [5:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_writedata,
    input wire logic [3:0]            avs_byteenable,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    input wire otps_pkg::otps_flags_t driveFlags,
    input wire logic [NUM_TERM-1:0]   outputPinIn,
    input wire logic [NUM_TERM-1:0]   outputPinOut,
    input wire logic [NUM_TERM-1:0]   outputPinOeN,
    input wire logic                  relayFirstContactPair,
    input wire logic                  relaySecondContactPair,
    input wire logic                  irq
);
    logic [11:0] polQ;
    logic [5:0]  fnQ;
    logic [5:0]  rfnQ;
    logic        expT;
    logic        expR;
    function automatic logic fsel(input logic [5:0] c, input otps_pkg::otps_flags_t f);
        case (c)
            6'h00: return f.motorRunning | f.dcBrakeActive;
            6'h33: return f.forwardRotationFlag;
            6'h34: return f.reverseRotationFlag;
            6'h35: return f.majorFailureFlag;
            6'h36: return f.windowCmpVoltageInput;
            6'h37: return f.windowCmpCurrentInput;
            6'h38: return f.windowCmpSecondVoltageInput;
            default: return 1'b0;
        endcase
    endfunction
    // Shadow of settings, taken at the completing edge of each write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            polQ <= 12'h1 << (2 * NUM_TERM);
            fnQ  <= 6'h00;
            rfnQ <= 6'h35;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == 6'h18) polQ <= avs_writedata[11:0];
            if (avs_address == 6'h00) fnQ <= avs_writedata[5:0];
            if (avs_address == 6'(4 * NUM_TERM)) rfnQ <= avs_writedata[5:0];
        end
    end
    assign expT = driveFlags.powerOn & (fsel(fnQ, driveFlags) ^ (polQ[1:0] == 2'h1));
    assign expR = driveFlags.powerOn
                & (fsel(rfnQ, driveFlags) ^ (polQ[2*NUM_TERM +: 2] == 2'h1));
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence brakeHeld;
        (driveFlags.powerOn && driveFlags.dcBrakeActive && fnQ == 6'h00
         && polQ[1:0] == 2'h0) [*2];
    endsequence
    sequence unpowered;
        !driveFlags.powerOn [*2];
    endsequence
    property termFollows;
        expT == $past(expT) |-> outputPinOeN[0] == !expT;
    endproperty
    term_polarity_a: assert property (termFollows)
        else $error("terminal 0 level wrong");
    run_brake_a: assert property (brakeHeld |-> !outputPinOeN[0])
        else $error("running lost while braking");
    relay_pol_a: assert property (expR == $past(expR) |-> relayFirstContactPair == expR)
        else $error("relay pair wrong");
    relay_pairs_a: assert property (relaySecondContactPair == !relayFirstContactPair)
        else $error("relay pairs not opposite");
    unpowered_rest_a: assert property (unpowered |-> !relayFirstContactPair && &outputPinOeN)
        else $error("unpowered outputs not at rest");
    oc_low_a: assert property (outputPinOut == '0)
        else $error("open collector driven high");
    wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
endmodule
bind otps_output_stage otps_properties #(.NUM_TERM(NUM_TERM)) u_otps_properties (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .driveFlags(driveFlags),
    .outputPinIn(outputPinIn), .outputPinOut(outputPinOut), .outputPinOeN(outputPinOeN),
    .relayFirstContactPair(relayFirstContactPair),
    .relaySecondContactPair(relaySecondContactPair), .irq(irq));
`default_nettype wire
